// ---- uart_irq_pkg.sv ----
package uart_irq_pkg;

  // -------------------------------------------------------------------
  // Register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_DATA      = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h04;
  localparam logic [7:0] OFS_IDENT     = 8'h08;
  localparam logic [7:0] OFS_LSR       = 8'h14;
  localparam logic [7:0] OFS_ALIAS_LO  = 8'h30;
  localparam logic [7:0] OFS_ALIAS_HI  = 8'h6C;
  localparam logic [7:0] OFS_FE_ALIAS  = 8'h98;
  localparam logic [7:0] OFS_RT_ALIAS  = 8'h9C;
  localparam logic [7:0] OFS_TET_ALIAS = 8'hA0;
  localparam logic [7:0] OFS_EVT_STAT  = 8'hC0;
  localparam logic [7:0] OFS_EVT_CLR   = 8'hC4;
  localparam logic [7:0] OFS_EVT_EN    = 8'hC8;

  // -------------------------------------------------------------------
  // Field positions and reset values
  // -------------------------------------------------------------------
  localparam int IE_RDA  = 0;
  localparam int IE_TX_HOLDING_EMPTY = 1;
  localparam int IE_LS   = 2;
  localparam int IE_TO   = 3;
  localparam int IE_PROG = 7;
  localparam int FC_FE   = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_TET  = 4;
  localparam int FC_RT   = 6;
  localparam int LS_DR   = 0;
  localparam int LS_OE   = 1;
  localparam int LS_PE   = 2;
  localparam int LS_FE   = 3;
  localparam int LS_BI   = 4;
  localparam int LS_TX_HOLDING_EMPTY = 5;
  localparam int LS_TEMT = 6;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] FCR_RST    = 8'h00;
  localparam logic [3:0] EVT_EN_RST = 4'h0;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

  // -------------------------------------------------------------------
  // Identification codes, highest priority first
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    ID_LINE    = 4'b0110,
    ID_DATA    = 4'b0100,
    ID_TIMEOUT = 4'b1100,
    ID_TX_HOLDING_EMPTY    = 4'b0010,
    ID_NONE    = 4'b0001
  } irq_id_e;

  // One received character with its line condition.
  typedef struct packed {
    logic       brk;
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_char_s;

endpackage

// ---- uart_irq_tx_holding_empty.sv ----
`timescale 1ns/100ps
// How it works
// - IRQ high while enabled source active.
// - Enable bits per source; timeout FIFO-only.
// - Ident 0001 idle; 0110 line status.
// - Ident 0100 data available or trigger.
// - Ident 1100 after four idle character times.
// - Ident 0010 holding empty or threshold.
// - Enable bit 7 selects threshold mode.
// - Two-bit threshold: empty, 2, quarter, half.
// - Threshold mode: status bit 5 means full.
// - FIFO disable kills threshold mode.
// - Otherwise bit 5 and interrupt mean empty.
// - Receive alias range pops one buffer.
// - Transmit alias range pushes one register.
// - FIFO-enable alias touches only bit 0.
// - Receive-trigger alias touches only bits 7:6.
// - Threshold alias touches only bits 5:4.
module uart_irq_tx_holding_empty #(
  parameter int DEPTH = 16
) (
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [7:0]               PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire logic                     RX_VALID,
  input  wire uart_irq_pkg::rx_char_s   RX_CHAR,
  input  wire logic                     CHAR_TICK,
  output logic                          TX_VALID,
  output logic      [7:0]               TX_DATA,
  input  wire logic                     TX_READY,
  output logic                          IRQ
);

  localparam int AW = $clog2(DEPTH);

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  logic [7:0]    ier_reg;
  logic [7:0]    fcr_reg;
  logic [3:0]    ls_err_reg;
  logic [7:0]    rx_mem [DEPTH];
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] rx_wr_reg, rx_rd_reg, tx_wr_reg, tx_rd_reg;
  logic [AW:0]   rx_cnt_reg, tx_cnt_reg;
  logic [2:0]    tick_cnt_reg;
  logic          tx_holding_empty_pend_reg;
  logic          tx_holding_empty_cond_d_reg;
  logic [3:0]    src_d_reg;
  logic [3:0]    evt_stat_reg;
  logic [3:0]    evt_en_reg;
  logic [31:0]   prdata_reg;
  logic [7:0]    snap_reg;
  logic          setup, acc_rd, acc_wr, mapped;
  logic          fe, prog_mode, in_alias;
  logic [AW:0]   cap, rx_trig, tx_thr;
  logic          rx_full, tx_full, rx_push, rx_pop, tx_push, tx_pop;
  logic          rx_clr, tx_clr;
  logic          tx_holding_empty_cond;
  logic          ls_src, rda_src, to_src;
  logic [3:0]    src;
  uart_irq_pkg::irq_id_e id;
  logic [7:0]    line_status_reg;

  // -------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------
  // Reads are sampled in the setup phase so that PRDATA is a flop; the
  // side effects of a read take place at the access edge.
  assign setup  = PSEL & ~PENABLE;
  assign acc_rd = PSEL & PENABLE & ~PWRITE;
  assign acc_wr = PSEL & PENABLE & PWRITE;
  assign in_alias = (PADDR >= uart_irq_pkg::OFS_ALIAS_LO) &&
                    (PADDR <= uart_irq_pkg::OFS_ALIAS_HI) && (PADDR[1:0] == 2'b00);

  // Every decoded offset; the alias window is decoded on its own above.
  always_comb begin
    case (PADDR)
      uart_irq_pkg::OFS_DATA, uart_irq_pkg::OFS_IRQ_EN, uart_irq_pkg::OFS_IDENT,
      uart_irq_pkg::OFS_LSR, uart_irq_pkg::OFS_FE_ALIAS, uart_irq_pkg::OFS_RT_ALIAS,
      uart_irq_pkg::OFS_TET_ALIAS, uart_irq_pkg::OFS_EVT_STAT,
      uart_irq_pkg::OFS_EVT_CLR, uart_irq_pkg::OFS_EVT_EN: mapped = 1'b1;
      default: mapped = in_alias;
    endcase
  end

  // Every register answers at once, so the bus never waits.
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA  = prdata_reg;

  // -------------------------------------------------------------------
  // Mode and levels
  // -------------------------------------------------------------------
  assign fe = fcr_reg[uart_irq_pkg::FC_FE];
  assign prog_mode = ier_reg[uart_irq_pkg::IE_PROG] & fe;
  // Without FIFOs each direction holds a single character.
  assign cap = fe ? (AW+1)'(DEPTH) : (AW+1)'(1);

  always_comb begin
    case (fcr_reg[uart_irq_pkg::FC_TET +: 2])
      2'd0:    tx_thr = '0;
      2'd1:    tx_thr = (AW+1)'(2);
      2'd2:    tx_thr = (AW+1)'(DEPTH / 4);
      default: tx_thr = (AW+1)'(DEPTH / 2);
    endcase
  end

  // Receive trigger levels: one, a quarter, a half and two short of full.
  always_comb begin
    case (fcr_reg[uart_irq_pkg::FC_RT +: 2])
      2'd0:    rx_trig = (AW+1)'(1);
      2'd1:    rx_trig = (AW+1)'(DEPTH / 4);
      2'd2:    rx_trig = (AW+1)'(DEPTH / 2);
      default: rx_trig = (AW+1)'(DEPTH - 2);
    endcase
  end

  assign rx_full = rx_cnt_reg >= cap;
  assign tx_full = tx_cnt_reg >= cap;
  assign rx_pop  = acc_rd & (PADDR == uart_irq_pkg::OFS_DATA | in_alias) & (rx_cnt_reg != '0);
  assign tx_push = acc_wr & (PADDR == uart_irq_pkg::OFS_DATA | in_alias) & ~tx_full;
  assign rx_push = RX_VALID & ~rx_full;
  assign tx_pop  = TX_VALID & TX_READY;
  assign TX_VALID = tx_cnt_reg != '0;
  assign TX_DATA  = tx_mem[tx_rd_reg];

  // Writes that reset a FIFO, including any change of the enable bit.
  always_comb begin
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    if (acc_wr && PADDR == uart_irq_pkg::OFS_IDENT) begin
      rx_clr = PWDATA[uart_irq_pkg::FC_RXRST] | (PWDATA[uart_irq_pkg::FC_FE] != fe);
      tx_clr = PWDATA[uart_irq_pkg::FC_TXRST] | (PWDATA[uart_irq_pkg::FC_FE] != fe);
    end else if (acc_wr && PADDR == uart_irq_pkg::OFS_FE_ALIAS) begin
      rx_clr = PWDATA[0] != fe;
      tx_clr = PWDATA[0] != fe;
    end
  end

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  // per-source enables
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ier_reg <= uart_irq_pkg::IRQ_EN_RST;
    end else if (acc_wr && PADDR == uart_irq_pkg::OFS_IRQ_EN) begin
      ier_reg <= PWDATA[7:0] & 8'h8F;
    end
  end

  // The FIFO reset bits are self-clearing and are never stored.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fcr_reg <= uart_irq_pkg::FCR_RST;
    end else if (acc_wr) begin
      case (PADDR)
        uart_irq_pkg::OFS_IDENT:     fcr_reg <= PWDATA[7:0] & 8'hF1;
        uart_irq_pkg::OFS_FE_ALIAS:  fcr_reg[uart_irq_pkg::FC_FE] <= PWDATA[0];
        uart_irq_pkg::OFS_RT_ALIAS:  fcr_reg[uart_irq_pkg::FC_RT +: 2] <= PWDATA[1:0];
        uart_irq_pkg::OFS_TET_ALIAS: fcr_reg[uart_irq_pkg::FC_TET +: 2] <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Receive and transmit storage
  // -------------------------------------------------------------------
  // Receive storage; a character that finds it full is lost and flagged.
  always_ff @(posedge CLK) begin
    if (RESET || rx_clr) begin
      rx_wr_reg  <= '0;
      rx_rd_reg  <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wr_reg] <= RX_CHAR.data;
        rx_wr_reg <= rx_wr_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rd_reg <= rx_rd_reg + 1'b1;
      end
      rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // Transmit storage; a write into a full store is dropped without notice.
  always_ff @(posedge CLK) begin
    if (RESET || tx_clr) begin
      tx_wr_reg  <= '0;
      tx_rd_reg  <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wr_reg] <= PWDATA[7:0];
        tx_wr_reg <= tx_wr_reg + 1'b1;
      end
      if (tx_pop) begin
        tx_rd_reg <= tx_rd_reg + 1'b1;
      end
      tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // -------------------------------------------------------------------
  // Line status
  // -------------------------------------------------------------------
  // cleared by status read
  // Only bits that the read returned are cleared, and a new error at
  // the same edge is kept, so no error is ever lost.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ls_err_reg <= '0;
    end else begin
      ls_err_reg <= (ls_err_reg & ~((acc_rd && PADDR == uart_irq_pkg::OFS_LSR) ?
                                    snap_reg[4:1] : 4'h0)) |
                    {RX_VALID & RX_CHAR.brk, RX_VALID & RX_CHAR.framing,
                     RX_VALID & RX_CHAR.parity, RX_VALID & rx_full};
    end
  end

  // Line status as software reads it.
  always_comb begin
    line_status_reg = '0;
    line_status_reg[uart_irq_pkg::LS_DR] = rx_cnt_reg != '0;
    line_status_reg[uart_irq_pkg::LS_BI:uart_irq_pkg::LS_OE] = ls_err_reg;
    line_status_reg[uart_irq_pkg::LS_TX_HOLDING_EMPTY] = prog_mode ? tx_full : (tx_cnt_reg == '0);
    line_status_reg[uart_irq_pkg::LS_TEMT] = (tx_cnt_reg == '0);
  end

  // -------------------------------------------------------------------
  // Interrupt sources
  // -------------------------------------------------------------------
  assign ls_src = |ls_err_reg;
  assign rda_src = fe ? (rx_cnt_reg >= rx_trig) : (rx_cnt_reg != '0);
  assign to_src = fe & (rx_cnt_reg != '0) & (tick_cnt_reg == uart_irq_pkg::TIMEOUT_CHARS);
  assign tx_holding_empty_cond = prog_mode ? (tx_cnt_reg <= tx_thr) : (tx_cnt_reg == '0);

  // Any traffic through the receive FIFO restarts the idle count.
  always_ff @(posedge CLK) begin
    if (RESET || rx_push || rx_pop || rx_cnt_reg == '0) begin
      tick_cnt_reg <= '0;
    end else if (CHAR_TICK && tick_cnt_reg != uart_irq_pkg::TIMEOUT_CHARS) begin
      tick_cnt_reg <= tick_cnt_reg + 3'h1;
    end
  end

  // transmit empty pending
  // The pending bit arms when the condition arises and set wins over
  // the clear from an ident read or a holding write in the same cycle.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_holding_empty_cond_d_reg <= 1'b0;
      tx_holding_empty_pend_reg   <= 1'b0;
    end else begin
      tx_holding_empty_cond_d_reg <= tx_holding_empty_cond;
      if (!tx_holding_empty_cond) begin
        tx_holding_empty_pend_reg <= 1'b0;
      end else if (!tx_holding_empty_cond_d_reg) begin
        tx_holding_empty_pend_reg <= 1'b1;
      end else if ((acc_rd && PADDR == uart_irq_pkg::OFS_IDENT &&
                    snap_reg[3:0] == uart_irq_pkg::ID_TX_HOLDING_EMPTY) ||
                   (tx_push && !prog_mode)) begin
        tx_holding_empty_pend_reg <= 1'b0;
      end
    end
  end

  // Each source is masked by its own enable bit.
  assign src = {ls_src & ier_reg[uart_irq_pkg::IE_LS],
                rda_src & ier_reg[uart_irq_pkg::IE_RDA],
                to_src & ier_reg[uart_irq_pkg::IE_TO],
                tx_holding_empty_pend_reg & ier_reg[uart_irq_pkg::IE_TX_HOLDING_EMPTY]};

  always_comb begin
    if (src[3]) begin
      id = uart_irq_pkg::ID_LINE;
    end else if (src[2]) begin
      id = uart_irq_pkg::ID_DATA;
    end else if (src[1]) begin
      id = uart_irq_pkg::ID_TIMEOUT;
    end else if (src[0]) begin
      id = uart_irq_pkg::ID_TX_HOLDING_EMPTY;
    end else begin
      id = uart_irq_pkg::ID_NONE;
    end
  end

  // -------------------------------------------------------------------
  // Event status, clear and enable
  // -------------------------------------------------------------------
  // A rising source sets its sticky bit; the set wins over a clear.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_d_reg    <= '0;
      evt_stat_reg <= '0;
      evt_en_reg   <= uart_irq_pkg::EVT_EN_RST;
    end else begin
      src_d_reg    <= src;
      evt_stat_reg <= (evt_stat_reg & ~((acc_wr && PADDR == uart_irq_pkg::OFS_EVT_CLR) ?
                                        PWDATA[3:0] : 4'h0)) | (src & ~src_d_reg);
      if (acc_wr && PADDR == uart_irq_pkg::OFS_EVT_EN) begin
        evt_en_reg <= PWDATA[3:0];
      end
    end
  end

  assign IRQ = (|src) | (|(evt_stat_reg & evt_en_reg));

  // -------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------
  // Captured in the setup cycle, which costs a flop but keeps PRDATA glitch free.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prdata_reg <= '0;
      snap_reg   <= '0;
    end else if (setup && !PWRITE) begin
      prdata_reg <= '0;
      case (PADDR)
        uart_irq_pkg::OFS_DATA:      prdata_reg[7:0] <= rx_mem[rx_rd_reg];
        uart_irq_pkg::OFS_IRQ_EN:    prdata_reg[7:0] <= ier_reg;
        uart_irq_pkg::OFS_IDENT: begin
          prdata_reg[7:0] <= {fe, fe, 2'b00, id};
          snap_reg        <= {4'h0, id};
        end
        uart_irq_pkg::OFS_LSR: begin
          prdata_reg[7:0] <= line_status_reg;
          snap_reg        <= line_status_reg;
        end
        uart_irq_pkg::OFS_FE_ALIAS:  prdata_reg[0] <= fe;
        uart_irq_pkg::OFS_RT_ALIAS:  prdata_reg[1:0] <= fcr_reg[uart_irq_pkg::FC_RT +: 2];
        uart_irq_pkg::OFS_TET_ALIAS: prdata_reg[1:0] <= fcr_reg[uart_irq_pkg::FC_TET +: 2];
        uart_irq_pkg::OFS_EVT_STAT:  prdata_reg[3:0] <= evt_stat_reg;
        uart_irq_pkg::OFS_EVT_EN:    prdata_reg[3:0] <= evt_en_reg;
        default: begin
          if (in_alias) begin
            prdata_reg[7:0] <= rx_mem[rx_rd_reg];
          end
        end
      endcase
    end
  end

endmodule

// ---- uart_irq_tx_holding_empty_checker.sv ----
`timescale 1ns/100ps
module uart_irq_tx_holding_empty_checker (
  input wire logic                   CLK,
  input wire logic                   RESET,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [7:0]             PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic [31:0]            PRDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  input wire logic                   RX_VALID,
  input wire uart_irq_pkg::rx_char_s RX_CHAR,
  input wire logic                   CHAR_TICK,
  input wire logic                   TX_VALID,
  input wire logic [7:0]             TX_DATA,
  input wire logic                   TX_READY,
  input wire logic                   IRQ
);
  logic fe_q;
  logic prog_q;
  wire  acc = PSEL && PENABLE;

  // -------------------------------------------------------------------
  // Mode mirror
  // -------------------------------------------------------------------
  // Tracks fifo enable and threshold select so bit 5 can be judged.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fe_q   <= 1'h0;
      prog_q <= 1'h0;
    end else if (acc && PWRITE) begin
      if (PADDR == 8'h08 || PADDR == 8'h98) fe_q <= PWDATA[0];
      if (PADDR == 8'h04) prog_q <= PWDATA[7];
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    return (a inside {8'h00, 8'h04, 8'h08, 8'h14, 8'h98, 8'h9C, 8'hA0, 8'hC0, 8'hC4, 8'hC8})
      || (a >= 8'h30 && a <= 8'h6C);
  endfunction

  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence rd_at(logic [7:0] a);
    acc && !PWRITE && PADDR == a;
  endsequence

  AST_SLVERR_MAP:
    assert property (acc && PADDR[1:0] == 2'h0 |-> PSLVERR == !mapped(PADDR))
    else $error("error response does not match the address map");
  AST_SLVERR_IDLE:
    assert property (!acc |-> !PSLVERR) else $error("error response outside access");
  AST_ERR_DATA:
    assert property (acc && !PWRITE && PSLVERR |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  AST_UPPER_ZERO:
    assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0) else $error("upper bits set");
  AST_READY:
    assert property (PSEL |-> PREADY) else $error("wait state inserted");
  AST_TX_HOLD:
    assert property (TX_VALID && !TX_READY && !(acc && PWRITE) |=> TX_VALID && $stable(TX_DATA))
    else $error("transmit head moved while stalled");
  AST_LSR_BIT5:
    assert property (rd_at(8'h14) ##0 !(fe_q && prog_q) |-> PRDATA[5] == PRDATA[6])
    else $error("holding empty flag differs from storage empty");
  AST_IDENT_CODE:
    assert property (rd_at(8'h08) |-> PRDATA[7:6] == {2{fe_q}}
      && PRDATA[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2}) else $error("bad ident value");
  AST_IDENT_IRQ:
    assert property (rd_at(8'h08) ##0 PRDATA[3:0] != 4'h1 |-> $past(IRQ))
    else $error("pending source without interrupt");
  AST_CLR_READ0:
    assert property (rd_at(8'hC4) |-> PRDATA == 32'h0) else $error("clear register readable");
endmodule

// ---- serial_peer.sv ----
`timescale 1ns/100ps
module serial_peer (
  input  wire logic                   clk,
  input  wire logic                   stall,
  output logic                        rx_valid,
  output uart_irq_pkg::rx_char_s      rx_char,
  output logic                        char_tick,
  input  wire logic                   tx_valid,
  input  wire logic [7:0]             tx_data,
  output logic                        tx_ready
);
  logic [7:0] got [$];

  initial begin
    rx_valid  = 1'h0;
    rx_char   = '0;
    char_tick = 1'h0;
    tx_ready  = 1'h0;
  end

  // One received character; the bus shows junk once the pulse is over.
  task automatic send(input uart_irq_pkg::rx_char_s c);
    @(posedge clk);
    rx_valid <= 1'h1;
    rx_char  <= c;
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_char  <= ~c;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      char_tick <= 1'h1;
      @(posedge clk);
      char_tick <= 1'h0;
    end
  endtask

  // Accepts transmit characters unless the bench asks for a stall.
  always @(posedge clk) begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule

// ---- uart_irq_tx_holding_empty_test.sv ----
`timescale 1ns/100ps
module uart_irq_tx_holding_empty_test;
  logic                   CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic                   RX_VALID, CHAR_TICK, TX_VALID, TX_READY, stall, err;
  logic [7:0]             PADDR, TX_DATA;
  logic [31:0]            PWDATA, PRDATA, rd;
  uart_irq_pkg::rx_char_s RX_CHAR;
  int                     miscompares, tests_run;
  localparam logic [31:0] M = 32'hFFFFFFFF;

  uart_irq_tx_holding_empty #(.DEPTH(16)) i_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR),
    .CHAR_TICK(CHAR_TICK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .IRQ(IRQ));
  serial_peer i_peer (.clk(CLK), .stall(stall), .rx_valid(RX_VALID), .rx_char(RX_CHAR),
    .char_tick(CHAR_TICK), .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));

  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One transfer; read data and the error flag are taken at the edge that ends it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL    <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'h1 && n < 16);
    if (PREADY !== 1'h1) begin
      miscompares++;
      final_report();
    end
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge CLK);
    chk("irq", {31'h0, e}, {31'h0, IRQ});
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    rdc("ident", 8'h08, M, 32'h1);
    rdc("enables", 8'h04, M, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk_irq(1'h0);
    $display("test reset finished");
  endtask

  task automatic t_tx_holding_empty();
    apb(1'h1, 8'h04, 32'h2);
    chk_irq(1'h1);
    rdc("ident", 8'h08, M, 32'h2);
    rdc("ident", 8'h08, M, 32'h1);
    chk_irq(1'h0);
    $display("test holding empty finished");
  endtask

  task automatic t_line();
    apb(1'h1, 8'h04, 32'h7);
    i_peer.send(11'h15A);
    rdc("ident", 8'h08, M, 32'h6);
    rdc("status", 8'h14, M, 32'h65);
    rdc("ident", 8'h08, M, 32'h4);
    rdc("rx data", 8'h30, M, 32'h5A);
    rdc("ident", 8'h08, M, 32'h1);
    $display("test line status finished");
  endtask

  // Threshold half, peer stalled while the transmit storage is filled.
  task automatic t_fifo();
    int n;
    apb(1'h1, 8'h08, 32'h31);
    apb(1'h1, 8'h04, 32'h82);
    apb(1'h0, 8'h08, 32'h0);
    rdc("tet alias", 8'hA0, M, 32'h3);
    rdc("fe alias", 8'h98, M, 32'h1);
    apb(1'h1, 8'h9C, 32'h2);
    rdc("rt alias", 8'h9C, M, 32'h2);
    rdc("tet alias", 8'hA0, M, 32'h3);
    rdc("status", 8'h14, 32'h20, 32'h0);
    stall <= 1'h1;
    apb(1'h1, 8'hA0, 32'h1);
    // Eight held characters sit above a quarter and exactly at half.
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        apb(1'h1, 8'hA0, 32'h2);
        rdc("ident", 8'h08, M, 32'hC1);
        apb(1'h1, 8'hA0, 32'h3);
        rdc("ident", 8'h08, M, 32'hC2);
      end
      apb(1'h1, 8'h30 + 8'(4 * i), 32'hA0 + 32'(i));
    end
    rdc("status", 8'h14, 32'h20, 32'h20);
    stall <= 1'h0;
    n = 0;
    while (i_peer.got.size() < 16 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      final_report();
    end
    for (int i = 0; i < 16; i++) chk("tx data", 32'hA0 + 32'(i), {24'h0, i_peer.got[i]});
    rdc("ident", 8'h08, M, 32'hC2);
    apb(1'h1, 8'h98, 32'h0);
    rdc("status", 8'h14, 32'h20, 32'h20);
    $display("test threshold finished");
  endtask

  task automatic t_timeout();
    apb(1'h1, 8'h98, 32'h1);
    apb(1'h1, 8'h04, 32'h9);
    i_peer.send(11'h03C);
    i_peer.ticks(4);
    rdc("ident", 8'h08, M, 32'hCC);
    rdc("events", 8'hC0, 32'h2, 32'h2);
    rdc("rx data", 8'h00, M, 32'h3C);
    rdc("ident", 8'h08, M, 32'hC1);
    rdc("clear reg", 8'hC4, M, 32'h0);
    chk_irq(1'h0);
    apb(1'h1, 8'hC8, 32'h2);
    chk_irq(1'h1);
    apb(1'h1, 8'hC8, 32'h0);
    chk_irq(1'h0);
    apb(1'h1, 8'hC8, 32'h2);
    apb(1'h1, 8'hC4, 32'h2);
    chk_irq(1'h0);
    rdc("events", 8'hC0, 32'h2, 32'h0);
    $display("test timeout finished");
  endtask

  initial begin
    RESET   = 1'h1;
    PSEL    = 1'h0;
    PENABLE = 1'h0;
    PWRITE  = 1'h0;
    PADDR   = 8'h00;
    PWDATA  = 32'h0;
    stall   = 1'h0;
    repeat (3) @(posedge CLK);
    RESET <= 1'h0;
    t_reset();
    t_tx_holding_empty();
    t_line();
    t_fifo();
    t_timeout();
    final_report();
  end
endmodule

bind uart_irq_tx_holding_empty uart_irq_tx_holding_empty_checker i_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR),
  .CHAR_TICK(CHAR_TICK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
  .IRQ(IRQ));
